// ==== cee_consts.vh ====
// Constants for the exception entry unit
`ifndef CEE_CONSTS_VH
`define CEE_CONSTS_VH
`define CEE_VEC_RESET 32'h00000000
`define CEE_VEC_UNDEF 32'h00000004
`define CEE_VEC_PABORT 32'h0000000c
`define CEE_VEC_DABORT 32'h00000010
`define CEE_SIG_ADDR 32'h00000014
`define CEE_VEC_IRQ 32'h00000018
`define CEE_VEC_FIQ 32'h0000001c
`define CEE_SIG_MAGIC 32'h27011970
`define CEE_MODE_USER 3'h0
`define CEE_MODE_FIQ 3'h1
`define CEE_MODE_IRQ 3'h2
`define CEE_MODE_ABT 3'h3
`define CEE_MODE_UND 3'h4
`define CEE_MODE_SVC 3'h5
`define CEE_ENTRY_CYCLES 3'h3
`define CEE_LAT_MAX 6'h32
`define CEE_LAT_NOLDM 6'h2a
`define CEE_LAT_COMPRESSED 6'h16
`define CEE_LAT_MIN 6'h05
`define CEE_BANK_LO 4'h8
`define CEE_BANK_SP 4'hd
`define CEE_BANK_LR 4'he
`define CEE_BANK_ROW 3'h1
`endif

// ==== cee_bank_mem.v ====
// Banked register storage with registered read data
`timescale 1ns/100ps
module cee_bank_mem #(
	parameter AW = 6,
	parameter DW = 32
) (
	// Clock
	input wire clk_sys,
	// Write port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	// Read port
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	always @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // cee_bank_mem

// ==== cee_exception_entry.v ====
// Exception prioritiser, vectoring, boot check and register banking
`timescale 1ns/100ps
`include "cee_consts.vh"
module cee_exception_entry (
	// Clock and reset
	input wire clk_sys,
	input wire reset,
	// Exception sources
	input wire fast_interrupt_request,
	input wire normal_interrupt_request,
	input wire data_abort,
	input wire prefetch_abort,
	input wire software_trap,
	input wire undefined_instr,
	input wire fast_mask,
	input wire normal_mask,
	// Pipeline status
	input wire instr_boundary,
	input wire [31:0] return_addr,
	input wire compressed_state,
	input wire load_multiple_instruction,
	// Boot signature check
	input wire boot_check_valid,
	input wire [31:0] boot_sig_word,
	input wire [31:0] page0_checksum,
	// Debug and power
	input wire debug_match,
	input wire debug_resume,
	input wire power_down,
	input wire [4:0] wake_event,
	// Register datapath
	input wire [3:0] reg_rd_addr,
	input wire reg_wr_en,
	input wire [3:0] reg_wr_addr,
	input wire [31:0] reg_wr_data,
	output wire [31:0] reg_rd_data,
	// Fetch control
	output reg exc_take,
	output reg [31:0] exc_vector,
	output reg [2:0] cpu_mode,
	output reg force_32bit_state,
	output reg boot_run_user,
	output reg boot_download,
	output reg debug_halted,
	output reg core_asleep,
	output reg [5:0] latency_bound,
	output reg [31:0] link_reg
);
	////////////////////////////////////////////////////////////////////////////////
	localparam ST_BOOT = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_ENTRY = 2'h2;
	localparam ST_DOWNLOAD = 2'h3;
	localparam BANK_AW = 6;
	localparam DATA_W = 32;

	reg [1:0] state;
	reg [1:0] next_state;
	reg fiq_s1, fiq_s2, irq_s1, irq_s2;
	reg [2:0] entry_cnt;
	reg [2:0] next_mode;
	reg [31:0] next_vector;
	reg pend;
	wire take_now;
	wire leave_now;

	assign take_now = (state == ST_RUN) && (next_state == ST_ENTRY);
	assign leave_now = (state == ST_ENTRY) && (next_state == ST_RUN);

	// Two flops per request; the first is read only by the second
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fiq_s1 <= 1'b0;
			fiq_s2 <= 1'b0;
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
		end else begin
			fiq_s1 <= fast_interrupt_request;
			fiq_s2 <= fiq_s1;
			irq_s1 <= normal_interrupt_request;
			irq_s2 <= irq_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fixed priority; trap and undefined never coincide so share one slot
	always @* begin
		pend = 1'b1;
		next_mode = cpu_mode;
		next_vector = exc_vector;
		if (data_abort) begin
			next_mode = `CEE_MODE_ABT;
			next_vector = `CEE_VEC_DABORT;
		end else if (fiq_s2 && !fast_mask) begin
			next_mode = `CEE_MODE_FIQ;
			next_vector = `CEE_VEC_FIQ;
		end else if (irq_s2 && !normal_mask) begin
			next_mode = `CEE_MODE_IRQ;
			next_vector = `CEE_VEC_IRQ;
		end else if (prefetch_abort) begin
			next_mode = `CEE_MODE_ABT;
			next_vector = `CEE_VEC_PABORT;
		end else if (software_trap) begin
			next_mode = `CEE_MODE_SVC;
			next_vector = `CEE_VEC_UNDEF;
		end else if (undefined_instr) begin
			next_mode = `CEE_MODE_UND;
			next_vector = `CEE_VEC_UNDEF;
		end else begin
			pend = 1'b0;
		end
	end

	// Either the fixed signature or the page checksum unlocks user code
	function sig_ok;
		input [31:0] word;
		input [31:0] sum;
		begin
			sig_ok = (word == `CEE_SIG_MAGIC) || (word == sum);
		end
	endfunction

	always @* begin
		next_state = state;
		case (state)
			ST_BOOT: begin
				if (boot_check_valid) begin
					if (sig_ok(boot_sig_word, page0_checksum)) begin
						next_state = ST_RUN;
					end else begin
						next_state = ST_DOWNLOAD;
					end
				end
			end
			ST_RUN: begin
				if (pend && instr_boundary && !debug_halted && !core_asleep) begin
					next_state = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				if (entry_cnt == `CEE_ENTRY_CYCLES) begin
					next_state = ST_RUN;
				end
			end
			ST_DOWNLOAD: next_state = ST_DOWNLOAD;
			default: next_state = ST_BOOT;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer state and entry step counter
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state <= ST_BOOT;
			entry_cnt <= 3'h0;
		end else begin
			state <= next_state;
			if (state == ST_ENTRY) begin
				entry_cnt <= entry_cnt + 3'h1;
			end else begin
				entry_cnt <= 3'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset itself is top priority: vector zero in supervisor mode
	// Fixed entry time keeps minimum at sync plus entry
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			exc_take <= 1'b0;
			exc_vector <= `CEE_VEC_RESET;
			cpu_mode <= `CEE_MODE_SVC;
			force_32bit_state <= 1'b1;
			link_reg <= 32'h00000000;
		end else begin
			exc_take <= 1'b0;
			if (take_now) begin
				exc_take <= 1'b1;
				exc_vector <= next_vector;
				cpu_mode <= next_mode;
				link_reg <= return_addr;
				force_32bit_state <= 1'b1;
			end else if (leave_now) begin
				force_32bit_state <= 1'b0;
			end
		end
	end

	// Boot outcome is registered from next_state, so it changes on the same edge as the sequencer state
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			boot_run_user <= 1'b0;
			boot_download <= 1'b0;
		end else begin
			boot_run_user <= (next_state == ST_RUN || next_state == ST_ENTRY);
			boot_download <= (next_state == ST_DOWNLOAD);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Match wins over resume so a fresh breakpoint is never lost
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			debug_halted <= 1'b0;
		end else if (debug_match) begin
			debug_halted <= 1'b1;
		end else if (debug_resume) begin
			debug_halted <= 1'b0;
		end
	end

	// Wake wins over power down so no wake event is slept through
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			core_asleep <= 1'b0;
		end else if (|wake_event) begin
			core_asleep <= 1'b0;
		end else if (power_down) begin
			core_asleep <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Advertised worst case depends on code style
	// Sync, longest load, abort entry and fast entry all fold into one figure
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			latency_bound <= `CEE_LAT_MAX;
		end else if (compressed_state) begin
			latency_bound <= `CEE_LAT_COMPRESSED;
		end else if (load_multiple_instruction) begin
			latency_bound <= `CEE_LAT_MAX;
		end else begin
			latency_bound <= `CEE_LAT_NOLDM;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bank select: fast mode banks 8..12, every mode except user banks 13 and 14
	// Banked rows sit above the sixteen user registers so they never alias
	function [5:0] bank_addr;
		input [3:0] r;
		input [2:0] m;
		begin
			if ((r == `CEE_BANK_SP || r == `CEE_BANK_LR) && m != `CEE_MODE_USER) begin
				bank_addr = {m + `CEE_BANK_ROW, r[2:0]};
			end else if (r >= `CEE_BANK_LO && r < `CEE_BANK_SP && m == `CEE_MODE_FIQ) begin
				bank_addr = {m + `CEE_BANK_ROW, r[2:0]};
			end else begin
				bank_addr = {2'h0, r};
			end
		end
	endfunction

	cee_bank_mem #(.AW(BANK_AW), .DW(DATA_W)) u_bank (
		.clk_sys(clk_sys),
		.wr_en(reg_wr_en),
		.wr_addr(bank_addr(reg_wr_addr, cpu_mode)),
		.wr_data(reg_wr_data),
		.rd_addr(bank_addr(reg_rd_addr, cpu_mode)),
		.rd_data(reg_rd_data)
	);
endmodule // cee_exception_entry

// ==== cee_exc_monitor.sv ====
// Checker for exception entry
`timescale 1ns/100ps
module cee_exc_monitor (
	// Watched ports
	input wire clk_sys,
	input wire reset,
	input wire data_abort,
	input wire boot_check_valid,
	input wire [31:0] boot_sig_word,
	input wire compressed_state,
	input wire [31:0] return_addr,
	input wire debug_halted,
	input wire exc_take,
	input wire [31:0] exc_vector,
	input wire [2:0] cpu_mode,
	input wire force_32bit_state,
	input wire boot_run_user,
	input wire [5:0] latency_bound,
	input wire [31:0] link_reg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	////////////////////////////////
	sequence s_quiet; !exc_take [*4]; endsequence
	property p_gap; exc_take |=> s_quiet; endproperty
	property p_dabort; exc_take && $past(data_abort) |-> exc_vector == 32'h10; endproperty
	property p_mode; exc_take |-> (exc_vector == 32'h1c) == (cpu_mode == 3'h1); endproperty
	property p_arm; exc_take |-> force_32bit_state; endproperty
	property p_link; exc_take |-> link_reg == $past(return_addr); endproperty
	property p_boot; boot_check_valid && boot_sig_word == 32'h27011970 |=> boot_run_user; endproperty
	// Three cycles so the registered bound has settled after any change
	property p_bound; compressed_state [*3] |-> latency_bound == 6'h16; endproperty
	property p_halt; $past(debug_halted) |-> !exc_take; endproperty
	a_gap: assert property (p_gap) else $error("entries too close");
	a_dabort: assert property (p_dabort) else $error("abort not first");
	a_mode: assert property (p_mode) else $error("wrong mode");
	a_arm: assert property (p_arm) else $error("not 32-bit");
	a_link: assert property (p_link) else $error("bad link");
	a_boot: assert property (p_boot) else $error("boot refused");
	a_bound: assert property (p_bound) else $error("bad bound");
	a_halt: assert property (p_halt) else $error("taken when halted");
endmodule // cee_exc_monitor
bind cee_exception_entry cee_exc_monitor u_mon (.*);

// ==== cee_periph_model.sv ====
// Peripheral model raising interrupt requests
`timescale 1ns/100ps
module cee_periph_model (
	// Commands and service
	input wire clk_sys,
	input wire [1:0] raise,
	input wire exc_take,
	input wire [31:0] exc_vector,
	// Requests
	output reg fast_interrupt_request = 1'b0,
	output reg normal_interrupt_request = 1'b0
);
	// Held as levels until serviced, so no request is lost
	always @(posedge clk_sys) begin
		if (raise[1])
			fast_interrupt_request <= 1'b1;
		else if (exc_take && exc_vector == 32'h1c)
			fast_interrupt_request <= 1'b0;
		if (raise[0])
			normal_interrupt_request <= 1'b1;
		else if (exc_take && exc_vector == 32'h18)
			normal_interrupt_request <= 1'b0;
	end
endmodule // cee_periph_model

// ==== cee_exception_entry_test.sv ====
// Bench for the exception entry unit
`timescale 1ns/100ps
module cee_exception_entry_test;
	logic clk_sys = 0, reset = 1, fast_mask = 0, normal_mask = 0, instr_boundary = 1, compressed_state = 0;
	logic load_multiple_instruction = 1, boot_check_valid = 0, debug_match = 0, debug_resume = 0;
	logic power_down = 0, reg_wr_en = 0;
	logic [1:0] raise = 0;
	logic [3:0] src = 0, reg_rd_addr = 0, reg_wr_addr = 0;
	logic [4:0] wake_event = 0;
	logic [31:0] return_addr = 0, boot_sig_word = 0, page0_checksum = 0, reg_wr_data = 0;
	wire fast_interrupt_request, normal_interrupt_request, exc_take, force_32bit_state, boot_run_user;
	wire boot_download, debug_halted, core_asleep;
	wire [2:0] cpu_mode;
	wire [5:0] latency_bound;
	wire [31:0] exc_vector, link_reg, reg_rd_data;
	wire data_abort = src[3], prefetch_abort = src[2], software_trap = src[1], undefined_instr = src[0];
	int mismatches = 0, n_compared = 0;
	cee_exception_entry u_dut (.*);
	cee_periph_model u_periph (.*);
	always #2 clk_sys = ~clk_sys;
	////////////////////////////////
	function automatic logic [5:0] exp_bound(input logic c, l);
		return c ? 6'h16 : l ? 6'h32 : 6'h2a;
	endfunction
	task automatic check(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic boot(input logic [31:0] w, c, input logic run);
		@(posedge clk_sys) reset <= 1;
		repeat (16) @(posedge clk_sys);
		reset <= 0;
		@(posedge clk_sys) {boot_check_valid, boot_sig_word, page0_checksum} <= {1'b1, w, c};
		@(posedge clk_sys) boot_check_valid <= 0;
		@(negedge clk_sys);
		check({boot_run_user, boot_download}, {run, !run});
	endtask
	task automatic take(input logic [1:0] r, input logic [3:0] s, input logic [31:0] v, input logic [2:0] m);
		int n = 0;
		@(posedge clk_sys) {return_addr, raise, src, instr_boundary} <= {$urandom, r, s, 1'b1};
		@(posedge clk_sys) raise <= 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (exc_take !== 1'b1 && n < 60);
		check({cpu_mode, exc_vector}, {m, v});
		check(link_reg, return_addr);
		check(force_32bit_state, 1);
		check(exc_vector[1:0], 0);
		check(n <= 50 && (r == 0 || n >= 3), 1);
		@(posedge clk_sys) src <= 0;
	endtask
	// Halt or sleep first, then show a pending request waits until release
	task automatic refuse(input logic [1:0] r, input logic [31:0] v, input logic [2:0] m, input logic dbg);
		@(posedge clk_sys) {debug_match, power_down} <= {dbg, !dbg};
		@(posedge clk_sys) {debug_match, power_down, raise} <= {2'b0, r};
		@(posedge clk_sys) raise <= 0;
		repeat (12) begin
			@(negedge clk_sys);
			check(exc_take, 0);
		end
		check({debug_halted, core_asleep}, {dbg, !dbg});
		@(posedge clk_sys) {debug_resume, wake_event, instr_boundary} <= {dbg, dbg ? 5'h0 : 5'($urandom_range(31, 1)), 1'b0};
		@(posedge clk_sys) {debug_resume, wake_event} <= 0;
		take(0, 0, v, m);
	endtask
	initial begin
		void'($urandom(32'he0595a97));
		boot($urandom, 32'h1, 0);
		boot(32'h5a5a0001, 32'h5a5a0001, 1);
		boot(32'h27011970, $urandom, 1);
		@(posedge clk_sys) {reg_wr_en, reg_wr_addr, reg_wr_data} <= {1'b1, 4'h3, $urandom};
		@(posedge clk_sys) {reg_wr_en, reg_rd_addr} <= {1'b0, 4'h3};
		@(posedge clk_sys);
		@(negedge clk_sys);
		check(reg_rd_data, reg_wr_data);
		@(posedge clk_sys) {reg_wr_en, reg_wr_addr, reg_wr_data} <= {1'b1, 4'hd, 32'h000417fc};
		@(posedge clk_sys) {reg_wr_en, reg_rd_addr} <= {1'b0, 4'hd};
		@(posedge clk_sys);
		@(negedge clk_sys);
		check(reg_rd_data, 32'h000417fc);
		take(2'b01, 0, 32'h18, 2);
		take(2'b11, 0, 32'h1c, 1);
		take(0, 0, 32'h18, 2);
		take(0, 4'hc, 32'h10, 3);
		take(0, 4'h6, 32'h0c, 3);
		take(0, 4'h2, 32'h04, 5);
		take(0, 4'h1, 32'h04, 4);
		refuse(2'b01, 32'h18, 2, 1);
		refuse(2'b10, 32'h1c, 1, 0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys) {compressed_state, load_multiple_instruction} <= 2'(i);
			repeat (3) @(negedge clk_sys);
			check(latency_bound, exp_bound(i[1], i[0]));
		end
		close_out();
	end
	initial begin
		#20000;
		mismatches++;
		close_out();
	end
endmodule // cee_exception_entry_test
